/* pio_hs_pkg.sv */
// Package for the parallel port handshake block: register map, fields, reset values
package pio_hs_pkg;

  // Register indices; the byte address is four times the index
  localparam logic [15:0] IDX_PORT_A_DATA  = 16'h1000;
  localparam logic [15:0] IDX_PIO_CTRL     = 16'h1002;
  localparam logic [15:0] IDX_PORT_C_DATA  = 16'h1003;
  localparam logic [15:0] IDX_PORT_B_DATA  = 16'h1004;
  localparam logic [15:0] IDX_PORT_C_LATCH = 16'h1005;
  localparam logic [15:0] IDX_PORT_C_DIR   = 16'h1007;
  localparam logic [15:0] IDX_MODE_CTRL    = 16'h1010;

  // Control register layout, bit 7 down to bit 0
  typedef struct packed {
    logic strobe_a_flag;
    logic strobe_a_irq_en;
    logic port_c_open_drain;
    logic full_handshake_sel;
    logic handshake_direction_sel;
    logic pulsed_strobe_sel;
    logic strobe_a_edge_sel;
    logic strobe_b_polarity;
  } parallel_io_ctrl_s;

  localparam logic [7:0] PARALLEL_IO_CTRL_RST      = 8'h03;
  localparam logic [7:0] PORT_RST      = 8'h00;
  localparam logic [7:0] DIR_RST       = 8'h00;
  localparam logic       SINGLE_CHIP_RST = 1'b1;
  localparam int         MODE_SINGLE_BIT = 0;

  // Strobe B pulse length in bus clock periods
  localparam int         STROBE_B_OUT_PULSE_CYC = 2;
  localparam logic [1:0] STROBE_B_OUT_PULSE_LD  = 2'(STROBE_B_OUT_PULSE_CYC);

endpackage : pio_hs_pkg

/* pio_hs.sv */
// Parallel port B/C handshake block with a classic Wishbone register slave
`timescale 1ns/1ps
module pio_hs
  import pio_hs_pkg::*;
#(
  parameter int ADR_W = 16
)(
  input  wire logic             I_CLK,      // Bus clock, 100 MHz
  input  wire logic             I_SRST,     // Synchronous reset, active high
  input  wire logic             I_CYC,      // Wishbone cycle
  input  wire logic             I_STB,      // Wishbone strobe
  input  wire logic             I_WE,       // Wishbone write enable
  input  wire logic [3:0]       I_SEL,      // Wishbone byte selects
  input  wire logic [ADR_W-1:0] I_ADR,      // Wishbone byte address
  input  wire logic [31:0]      I_DAT,      // Wishbone write data
  output logic      [31:0]      O_DAT,      // Wishbone read data
  output logic                  O_ACK,      // Wishbone acknowledge
  input  wire logic             I_STROBE_A_IN,     // Strobe A pin
  output logic                  O_STROBE_B_OUT,     // Strobe B pin
  output logic                  O_IRQ,      // Strobe A interrupt request
  output logic      [7:0]       O_PB,       // Port B pins
  input  wire logic [7:0]       I_PC,       // Port C pin levels
  output logic      [7:0]       O_PC,       // Port C pin drive value
  output logic      [7:0]       O_PC_OE     // Port C output enables, high drives
);

  initial begin
    if (ADR_W < 15 || ADR_W > 32)
      $error("ADR_W must be 15 to 32");
  end

  parallel_io_ctrl_s       parallel_io_ctrl_ff;
  logic [7:0]  pa_ff, pb_ff, pc_ff, pcl_ff, dir_ff;
  logic        single_ff;
  logic        ack_ff;
  logic [31:0] dat_ff;
  logic        sa1_ff, sa2_ff, sa3_ff;
  logic        arm_ff;
  logic        hs_ff;
  logic [1:0]  pulse_ff;
  logic        strobe_b_out_ff, irq_ff;
  logic [7:0]  pbo_ff, pco_ff, pcoe_ff;

  // Bus decode
  wire       acc    = I_CYC & I_STB & ~ack_ff;
  wire       wr     = acc & I_WE & I_SEL[0];
  wire       rd     = acc & ~I_WE;
  wire [7:0] wd     = I_DAT[7:0];
  wire       hit_pa = I_ADR == ADR_W'({IDX_PORT_A_DATA, 2'b00});
  wire       hit_ct = I_ADR == ADR_W'({IDX_PIO_CTRL, 2'b00});
  wire       hit_pc = I_ADR == ADR_W'({IDX_PORT_C_DATA, 2'b00});
  wire       hit_pb = I_ADR == ADR_W'({IDX_PORT_B_DATA, 2'b00});
  wire       hit_cl = I_ADR == ADR_W'({IDX_PORT_C_LATCH, 2'b00});
  wire       hit_dr = I_ADR == ADR_W'({IDX_PORT_C_DIR, 2'b00});
  wire       hit_md = I_ADR == ADR_W'({IDX_MODE_CTRL, 2'b00});

  wire pb_wr  = wr & hit_pb;
  wire cl_wr  = wr & hit_cl;
  wire cl_rd  = rd & hit_cl;
  wire ct_rd  = rd & hit_ct;
  wire ct_wr  = wr & hit_ct;

  // Mode decode
  wire full   = parallel_io_ctrl_ff.full_handshake_sel & single_ff;
  wire out_hs = full & parallel_io_ctrl_ff.handshake_direction_sel;
  wire in_hs  = full & ~parallel_io_ctrl_ff.handshake_direction_sel;

  // Strobe A edge and level after the synchroniser
  wire strobe_a_in_rise = sa2_ff & ~sa3_ff;
  wire strobe_a_in_fall = ~sa2_ff & sa3_ff;
  wire strobe_a_in_edge = single_ff & (parallel_io_ctrl_ff.strobe_a_edge_sel ? strobe_a_in_rise : strobe_a_in_fall);
  wire strobe_a_in_lvl  = sa2_ff == parallel_io_ctrl_ff.strobe_a_edge_sel;

  // Flag set and clear
  wire flag_clr  = arm_ff & (out_hs ? cl_wr : cl_rd);
  wire nxt_flag  = strobe_a_in_edge | (parallel_io_ctrl_ff.strobe_a_flag & ~flag_clr);
  wire nxt_arm   = (ct_rd & parallel_io_ctrl_ff.strobe_a_flag) | (arm_ff & ~flag_clr & ~ct_rd);

  // Handshake strobe B state
  wire hs_done   = in_hs ? cl_rd : cl_wr;
  wire hs_init   = ct_wr & wd[4] & ~wd[3];
  wire pulse_go  = single_ff & (full ? (parallel_io_ctrl_ff.pulsed_strobe_sel & hs_done)
                                     : pb_wr);
  wire strobe_b_out_act  = single_ff & ((full & ~parallel_io_ctrl_ff.pulsed_strobe_sel) ? hs_ff
                                                                    : pulse_ff != 2'b00);
  wire nxt_strobe_b_out  = parallel_io_ctrl_ff.strobe_b_polarity ? strobe_b_out_act : ~strobe_b_out_act;

  // Port C drive; with push-pull, the three-state variation drives all lines while strobe A is active
  wire       tri_drv = out_hs & strobe_a_in_lvl;
  wire [7:0] pc_val  = tri_drv ? pcl_ff : pc_ff;
  wire [7:0] pc_en   = single_ff ? (tri_drv ? 8'hFF : dir_ff) : 8'h00;
  wire [7:0] nxt_pco = parallel_io_ctrl_ff.port_c_open_drain ? 8'h00 : pc_val;
  wire [7:0] nxt_pcoe = parallel_io_ctrl_ff.port_c_open_drain ? (pc_en & ~pc_val) : pc_en;

  // Port C reads pins for inputs and the data register for outputs
  wire [7:0] pc_rd = (I_PC & ~dir_ff) | (pc_ff & dir_ff);

  wire [7:0] rd_byte = hit_pa ? pa_ff :
                       hit_ct ? parallel_io_ctrl_ff :
                       hit_pc ? pc_rd :
                       hit_pb ? pb_ff :
                       hit_cl ? pcl_ff :
                       hit_dr ? dir_ff :
                       hit_md ? {7'h00, single_ff} : 8'h00;

  // Bus slave: one wait state, unmapped reads return zero
  always_ff @(posedge I_CLK)
  begin
    if (I_SRST)
    begin
      ack_ff <= 1'b0;
      dat_ff <= 32'h0000_0000;
    end
    else
    begin
      ack_ff <= acc;
      dat_ff <= rd ? {24'h00_0000, rd_byte} : 32'h0000_0000;
    end
  end

  // Software registers
  always_ff @(posedge I_CLK)
  begin
    if (I_SRST)
    begin
      pa_ff     <= PORT_RST;
      pb_ff     <= PORT_RST;
      pc_ff     <= PORT_RST;
      dir_ff    <= DIR_RST;
      single_ff <= SINGLE_CHIP_RST;
    end
    else
    begin
      if (wr & hit_pa)
        pa_ff <= wd;
      if (pb_wr)
        pb_ff <= wd;
      if ((wr & hit_pc) | cl_wr)
        pc_ff <= wd;
      if (wr & hit_dr)
        dir_ff <= wd;
      if (wr & hit_md)
        single_ff <= wd[MODE_SINGLE_BIT];
    end
  end

  // Control register; the flag bit is hardware owned
  always_ff @(posedge I_CLK)
  begin
    if (I_SRST)
      parallel_io_ctrl_ff <= PARALLEL_IO_CTRL_RST;
    else if (ct_wr)
      parallel_io_ctrl_ff <= {nxt_flag, wd[6:0]};
    else
      parallel_io_ctrl_ff.strobe_a_flag <= nxt_flag;
  end

  // Strobe A synchroniser and edge history
  always_ff @(posedge I_CLK)
  begin
    if (I_SRST)
    begin
      sa1_ff <= 1'b0;
      sa2_ff <= 1'b0;
      sa3_ff <= 1'b0;
      arm_ff <= 1'b0;
    end
    else
    begin
      sa1_ff <= I_STROBE_A_IN;
      sa2_ff <= sa1_ff;
      sa3_ff <= sa2_ff;
      arm_ff <= nxt_arm;
    end
  end

  // Latch: strobe A edge captures pins in input modes, software writes it too
  always_ff @(posedge I_CLK)
  begin
    if (I_SRST)
      pcl_ff <= PORT_RST;
    else if (strobe_a_in_edge & ~out_hs)
      pcl_ff <= I_PC;
    else if (cl_wr)
      pcl_ff <= wd;
  end

  // Interlocked handshake level and pulse counter
  always_ff @(posedge I_CLK)
  begin
    if (I_SRST)
    begin
      hs_ff    <= 1'b0;
      pulse_ff <= 2'b00;
    end
    else
    begin
      if (hs_init)
        hs_ff <= 1'b1;
      else if (strobe_a_in_edge & full)
        hs_ff <= 1'b0;
      else if (hs_done & full)
        hs_ff <= 1'b1;
      else if (ct_wr)
        hs_ff <= 1'b0;
      if (pulse_go)
        pulse_ff <= STROBE_B_OUT_PULSE_LD;
      else if (pulse_ff != 2'b00)
        pulse_ff <= pulse_ff - 2'b01;
    end
  end

  // Registered pin outputs
  always_ff @(posedge I_CLK)
  begin
    if (I_SRST)
    begin
      // Strobe B comes out of reset at its inactive level for the reset polarity
      strobe_b_out_ff <= ~PARALLEL_IO_CTRL_RST[0];
      irq_ff  <= 1'b0;
      pbo_ff  <= PORT_RST;
      pco_ff  <= PORT_RST;
      pcoe_ff <= DIR_RST;
    end
    else
    begin
      strobe_b_out_ff <= nxt_strobe_b_out;
      irq_ff  <= parallel_io_ctrl_ff.strobe_a_flag & parallel_io_ctrl_ff.strobe_a_irq_en;
      pbo_ff  <= single_ff ? pb_ff : PORT_RST;
      pco_ff  <= nxt_pco;
      pcoe_ff <= nxt_pcoe;
    end
  end

  assign O_DAT   = dat_ff;
  assign O_ACK   = ack_ff;
  assign O_STROBE_B_OUT  = strobe_b_out_ff;
  assign O_IRQ   = irq_ff;
  assign O_PB    = pbo_ff;
  assign O_PC    = pco_ff;
  assign O_PC_OE = pcoe_ff;

  default clocking cb @(posedge I_CLK); endclocking
  default disable iff (I_SRST);

  strobe_b_out_pulse_len_a: assert property (
    $rose(pulse_ff == STROBE_B_OUT_PULSE_LD) |-> ##1 (pulse_ff != 2'b00) ##1 (pulse_ff == 2'b00)
  ) else $error("strobe B pulse not two cycles");

  strobe_b_out_polarity_a: assert property (
    O_STROBE_B_OUT == ($past(parallel_io_ctrl_ff.strobe_b_polarity) ? $past(strobe_b_out_act) : ~$past(strobe_b_out_act))
  ) else $error("strobe B level wrong for polarity");

  latch_capture_a: assert property (
    (strobe_a_in_edge & ~out_hs) |=> pcl_ff == $past(I_PC)
  ) else $error("latch missed pin levels");

  flag_set_a: assert property (
    strobe_a_in_edge |=> parallel_io_ctrl_ff.strobe_a_flag
  ) else $error("flag not set on edge");

  flag_hold_a: assert property (
    (parallel_io_ctrl_ff.strobe_a_flag & ~arm_ff) |=> parallel_io_ctrl_ff.strobe_a_flag
  ) else $error("flag cleared without control read");

  irq_gate_a: assert property (
    O_IRQ |-> $past(parallel_io_ctrl_ff.strobe_a_irq_en) & $past(parallel_io_ctrl_ff.strobe_a_flag)
  ) else $error("interrupt without enable and flag");

  open_drain_a: assert property (
    parallel_io_ctrl_ff.port_c_open_drain ##1 parallel_io_ctrl_ff.port_c_open_drain |-> O_PC == 8'h00
  ) else $error("open-drain port drove high");

  ready_neg_a: assert property (
    (in_hs & ~parallel_io_ctrl_ff.pulsed_strobe_sel & strobe_a_in_edge & ~ct_wr) |=> ##1 strobe_b_out_act == 1'b0
  ) else $error("ready not negated after strobe A");

  tri_drive_a: assert property (
    (tri_drv & single_ff) |=> O_PC_OE == (parallel_io_ctrl_ff.port_c_open_drain ? ~O_PC & O_PC_OE : 8'hFF)
  ) else $error("three-state variation did not drive port C");

  bus_ack_a: assert property (
    (I_CYC & I_STB & ~O_ACK) |=> O_ACK ##1 ~O_ACK
  ) else $error("bus acknowledge timing wrong");

  // Handshake strobe B set and start of its pulses
  ready_reassert_a: assert property (
    (in_hs & ~parallel_io_ctrl_ff.pulsed_strobe_sel & cl_rd & ~strobe_a_in_edge) |=> hs_ff
  ) else $error("ready not reasserted after latch read");

  out_ready_a: assert property (
    (out_hs & ~parallel_io_ctrl_ff.pulsed_strobe_sel & cl_wr & ~strobe_a_in_edge) |=> hs_ff
  ) else $error("output ready not asserted after latch write");

  hs_pulse_start_a: assert property (
    (full & parallel_io_ctrl_ff.pulsed_strobe_sel & hs_done) |=> pulse_ff == STROBE_B_OUT_PULSE_LD
  ) else $error("handshake pulse not started");

  pb_pulse_start_a: assert property (
    (pb_wr & single_ff & ~full) |=> pulse_ff == STROBE_B_OUT_PULSE_LD
  ) else $error("port B write gave no strobe pulse");

  strobe_b_out_idle_a: assert property (
    $past(~single_ff) |-> O_STROBE_B_OUT == ~$past(parallel_io_ctrl_ff.strobe_b_polarity)
  ) else $error("strobe B not inactive outside single-chip mode");

  // Flag and interrupt follow-up
  flag_clear_a: assert property (
    (flag_clr & ~strobe_a_in_edge) |=> ~parallel_io_ctrl_ff.strobe_a_flag
  ) else $error("flag not cleared by latch access");

  irq_follow_a: assert property (
    O_IRQ == ($past(parallel_io_ctrl_ff.strobe_a_flag) & $past(parallel_io_ctrl_ff.strobe_a_irq_en))
  ) else $error("interrupt does not follow enabled flag");

  // Strobe A edge detection
  edge_select_a: assert property (
    strobe_a_in_edge |-> (parallel_io_ctrl_ff.strobe_a_edge_sel ? sa2_ff : ~sa2_ff)
  ) else $error("edge of wrong direction accepted");

  sync_edge_a: assert property (
    strobe_a_in_edge |=> ~strobe_a_in_edge
  ) else $error("one transition gave two edge events");

  // Port C and port B drive
  push_pull_a: assert property (
    ~$past(parallel_io_ctrl_ff.port_c_open_drain) |-> O_PC_OE == $past(pc_en)
  ) else $error("push-pull enables do not follow direction");

  tri_follow_a: assert property (
    (out_hs & ~strobe_a_in_lvl & ~parallel_io_ctrl_ff.port_c_open_drain) |=> O_PC_OE == $past(dir_ff)
  ) else $error("three-state lines do not follow direction");

  latch_write_a: assert property (
    (cl_wr & (out_hs | ~strobe_a_in_edge)) |=> pcl_ff == $past(wd)
  ) else $error("latch write lost");

  pc_read_a: assert property (
    (rd & hit_pc) |=> O_DAT[7:0] == (($past(I_PC) & ~$past(dir_ff)) | ($past(pc_ff) & $past(dir_ff)))
  ) else $error("port C read mixes pins and register wrongly");

  mode_gate_a: assert property (
    $past(~single_ff) |-> (O_PB == 8'h00) && (O_PC_OE == 8'h00)
  ) else $error("ports driven outside single-chip mode");

  dir_reset_a: assert property (
    $past(I_SRST) |-> dir_ff == DIR_RST
  ) else $error("direction not cleared by reset");

endmodule : pio_hs

/* pio_partner.sv */
// Model of the external system on strobe A, strobe B and port C
`timescale 1ns/1ps
module pio_partner (
  input  wire logic       clk,   // Bus clock
  input  wire logic       strobe_b_out,  // Strobe B from the block
  input  wire logic [7:0] pc,    // Resolved port C pins
  output logic            strobe_a_in,  // Strobe A to the block
  output logic      [7:0] drv,   // Port C drive value
  output logic      [7:0] en     // Port C drive enables
);
  initial
  begin
    strobe_a_in = 1'b0;
    drv  = 8'h00;
    en   = 8'h00;
  end
  task automatic hold(input logic v);
    @(posedge clk);
    strobe_a_in <= v;
    repeat (8) @(posedge clk);
  endtask : hold
  // Data first, then the selected edge; lines are released afterwards
  task automatic send(input logic [7:0] d, input logic rise);
    @(posedge clk);
    drv <= d;
    en  <= 8'hFF;
    hold(~rise);
    hold(rise);
    en  <= 8'h00;
    drv <= ~d;
    hold(~rise);
  endtask : send
  task automatic take(input logic rise, input logic pol, output logic [7:0] d);
    int k;
    k = 0;
    @(posedge clk);
    while (strobe_b_out !== pol && k < 50)
    begin
      @(posedge clk);
      k++;
    end
    d = pc;
    hold(rise);
    hold(~rise);
  endtask : take
endmodule : pio_partner

/* tb_top.sv */
// Self-checking bench for the parallel port handshake block
`timescale 1ns/1ps
module tb_top;
  import pio_hs_pkg::*;
  logic        I_CLK = 0, I_SRST = 1, I_CYC = 0, I_STB = 0, I_WE = 0;
  logic [3:0]  I_SEL = 4'h0;
  logic [15:0] I_ADR = 16'h0000;
  logic [31:0] I_DAT = 32'h0000_0000, O_DAT;
  logic        O_ACK, O_STROBE_B_OUT, O_IRQ, strobe_a_in;
  logic [7:0]  O_PB, O_PC, O_PC_OE, pc, drv, en, d, g;
  logic [7:0]  expq[$];
  logic [31:0] seed = 32'hc87d_2d5f;
  int          error_cnt = 0, num_checks = 0, n;
  always #5 I_CLK = ~I_CLK;
  // Driven lines win, released lines float up
  assign pc = (O_PC_OE & O_PC) | (~O_PC_OE & en & drv) | (~O_PC_OE & ~en);
  pio_hs u_pio_hs (.I_CLK(I_CLK), .I_SRST(I_SRST), .I_CYC(I_CYC), .I_STB(I_STB),
    .I_WE(I_WE), .I_SEL(I_SEL), .I_ADR(I_ADR), .I_DAT(I_DAT), .O_DAT(O_DAT),
    .O_ACK(O_ACK), .I_STROBE_A_IN(strobe_a_in), .O_STROBE_B_OUT(O_STROBE_B_OUT), .O_IRQ(O_IRQ), .O_PB(O_PB),
    .I_PC(pc), .O_PC(O_PC), .O_PC_OE(O_PC_OE));
  pio_partner u_pio_partner (.clk(I_CLK), .strobe_b_out(O_STROBE_B_OUT), .pc(pc), .strobe_a_in(strobe_a_in),
    .drv(drv), .en(en));
  function automatic logic [7:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[7:0];
  endfunction : rnd
  task automatic chk(input logic [7:0] gv, input logic [7:0] ev);
    num_checks++;
    if (gv !== ev)
    begin
      error_cnt++;
      $display("wrong value at %0t: got %h exp %h", $time, gv, ev);
    end
  endtask : chk
  task automatic final_report();
    $display("checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : final_report
  task automatic wb(input logic we, input logic [15:0] idx, input logic [7:0] v);
    int k;
    @(posedge I_CLK);
    I_CYC <= 1'b1;
    I_STB <= 1'b1;
    I_WE  <= we;
    I_SEL <= 4'hF;
    I_ADR <= idx << 2;
    I_DAT <= {24'h0, v};
    if (!we)
      expq.push_back(v);
    k = 0;
    do
    begin
      @(posedge I_CLK);
      k++;
    end
    while (O_ACK !== 1'b1 && k < 20);
    if (O_ACK !== 1'b1)
    begin
      error_cnt++;
      final_report();
    end
    I_CYC <= 1'b0;
    I_STB <= 1'b0;
  endtask : wb
  task automatic settle(input int c);
    repeat (c) @(posedge I_CLK);
    #1;
  endtask : settle
  task automatic cnt(input logic lvl);
    n = 0;
    repeat (8)
    begin
      #1;
      if (O_STROBE_B_OUT === lvl)
        n++;
      @(posedge I_CLK);
    end
  endtask : cnt
  always @(posedge I_CLK)
    if (O_ACK === 1'b1 && I_WE === 1'b0 && expq.size() > 0)
      chk(O_DAT[7:0], expq.pop_front());
  initial
  begin
    #500_000;
    error_cnt++;
    final_report();
  end
  initial
  begin
    repeat (2) @(posedge I_CLK);
    I_SRST <= 1'b0;
    wb(0, IDX_PIO_CTRL, PARALLEL_IO_CTRL_RST);
    wb(0, IDX_PORT_C_DIR, DIR_RST);
    d = rnd();
    wb(1, IDX_PORT_B_DATA, d);
    cnt(1'b1);
    chk(8'(n), 8'h02);
    chk(O_PB, d);
    wb(1, IDX_PIO_CTRL, 8'h02);
    wb(1, IDX_PORT_B_DATA, ~d);
    cnt(1'b0);
    chk(8'(n), 8'h02);
    wb(1, IDX_PIO_CTRL, 8'h42);
    wb(1, IDX_PORT_C_DIR, 8'h0F);
    wb(1, IDX_PORT_C_DATA, 8'hA5);
    settle(2);
    chk(O_PC_OE, 8'h0F);
    d = rnd();
    u_pio_partner.send(d, 1'b1);
    chk(8'(O_IRQ), 8'h01);
    wb(0, IDX_PORT_C_DATA, 8'hF5);
    wb(0, IDX_PIO_CTRL, 8'hC2);
    wb(0, IDX_PORT_C_LATCH, {d[7:4], 4'h5});
    wb(0, IDX_PIO_CTRL, 8'h42);
    wb(1, IDX_PIO_CTRL, 8'h00);
    u_pio_partner.send(8'h3C, 1'b0);
    chk(8'(O_IRQ), 8'h00);
    wb(0, IDX_PIO_CTRL, 8'h80);
    wb(0, IDX_PORT_C_LATCH, 8'h35);
    wb(1, IDX_PIO_CTRL, 8'h13);
    settle(2);
    chk(8'(O_STROBE_B_OUT), 8'h01);
    u_pio_partner.send(8'h96, 1'b1);
    chk(8'(O_STROBE_B_OUT), 8'h00);
    wb(0, IDX_PORT_C_LATCH, 8'h95);
    settle(3);
    chk(8'(O_STROBE_B_OUT), 8'h01);
    wb(1, IDX_PIO_CTRL, 8'h1F);
    wb(1, IDX_PORT_C_LATCH, 8'h77);
    cnt(1'b1);
    chk(8'(n), 8'h02);
    wb(1, IDX_PIO_CTRL, 8'h1B);
    wb(1, IDX_PORT_C_DIR, 8'hFF);
    d = rnd();
    wb(1, IDX_PORT_C_LATCH, d);
    settle(2);
    chk(8'(O_STROBE_B_OUT), 8'h01);
    u_pio_partner.take(1'b1, 1'b1, g);
    chk(g, d);
    chk(8'(O_STROBE_B_OUT), 8'h00);
    wb(1, IDX_PORT_C_DIR, 8'h00);
    settle(2);
    chk(O_PC_OE, 8'h00);
    u_pio_partner.hold(1'b1);
    chk(O_PC_OE, 8'hFF);
    chk(O_PC, d);
    u_pio_partner.hold(1'b0);
    chk(O_PC_OE, 8'h00);
    wb(1, IDX_PIO_CTRL, 8'h23);
    wb(1, IDX_PORT_C_DIR, 8'hFF);
    wb(1, IDX_PORT_C_DATA, 8'h0F);
    settle(2);
    chk(O_PC_OE, 8'hF0);
    wb(0, 16'h1001, 8'h00);
    wb(1, IDX_MODE_CTRL, 8'h00);
    settle(2);
    chk(O_PB, 8'h00);
    final_report();
  end
endmodule : tb_top
